// ---- hw/line_clock_divider.sv ----
// Line clock enable divider and pixel clock phase.
// Assumes one system clock; the select may change at any time.
`timescale 1ns/1ps
`include "sensor_timing_regs.svh"
module line_clock_divider
  import sensor_timing_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] divide_sel,
  output logic            line_tick,
  output logic            phase_high
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       phase_reg;
  logic       phase_next;
  logic [2:0] last;
  logic [2:0] half;

  function automatic logic [2:0] div_last(input logic [1:0] sel);
    if (sel == `DIV_BY2) begin
      return `DIV2_LAST;
    end else if (sel == `DIV_BY4) begin
      return `DIV4_LAST;
    end else if (sel == `DIV_BY6) begin
      return `DIV6_LAST;
    end
    return `DIV1_LAST;
  endfunction

  // =====================================================
  // Divider
  always_comb begin
    last       = div_last(divide_sel);
    half       = 3'((4'(last) + 4'h1) >> 1);
    cnt_next   = (cnt_reg >= last) ? 3'h0 : cnt_reg + 3'h1;
    // Undivided rate cannot toggle from a flop; phase stays high
    phase_next = (divide_sel == `DIV_UNDIVIDED) || (cnt_next < half);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 3'h0;
      phase_reg <= 1'b1;
    end else begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign line_tick  = (cnt_reg >= last);
  assign phase_high = phase_reg;

endmodule

// ---- hw/sensor_frame_timing.sv ----
// Row, frame, pixel clock and still capture timing of the sensor.
// Assumes static configuration within a frame and a synchronous pin.
`timescale 1ns/1ps
`include "sensor_timing_regs.svh"
// Summary of operation
// - Line clock is system clock undivided or divided by 2, 4 or 6.
// - Pixel clock runs free at a divided line clock rate by default; undivided it stays high.
// - Data ready mode pulses pixel clock only for valid pixels.
// - Invert bit flips the pixel clock polarity.
// - Pixels per row are last minus first column plus one, halved if subsampled.
// - Row lasts 140 cycles plus overhead plus pixels plus row extension.
// - Partial exposure adds 34 cycles per row, otherwise none.
// - Row extension of 0 to 8191 line cycles lengthens every row.
// - Rows read are last minus first row plus one, halved if subsampled.
// - Frame extension of 0 to 32767 row times lengthens each video or freeze frame.
// - Partial exposure resets the row lying a set count ahead of readout.
// - Partial exposure is off when its enable or ahead count is zero.
// - No partial exposure while in any still capture state.
// - Start in video; enable moves to freeze at frame end; clear returns.
// - Trigger is a single pulse, or a level while the pin is held.
// - Trigger starts array reset, then capture, then readout.
// - Shutter mode: strobe off in 1 to 8 reset frames, on in capture.
// - Capture period is 0 to 65535 row times.
// - Normal mode: 0 to 8 reset frames, strobe on in capture and readout.
// - After readout the sequencer returns to freeze.
// - If enable was cleared, readout ends in video instead.
module sensor_frame_timing
  import sensor_timing_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     rst,
  input  timing_cfg_s   timing_cfg,
  input  still_cfg_s    still_cfg,
  input  wire logic     snapshot_pin,
  output logic          pixel_clock,
  output logic          line_tick,
  output video_timing_s video_timing,
  output logic          strobe_sync,
  output capture_state_e capture_state
);

  // =====================================================
  // Declarations
  logic           pclk_raw;
  logic           trigger;
  logic           restart;
  logic [11:0]    npix;
  logic [11:0]    nrows;
  logic           eff_partial;
  logic [14:0]    row_len;
  logic [14:0]    pix_lo;
  logic [16:0]    frame_len;
  logic           row_last;
  logic           row_end;
  logic           frame_end;
  logic           active_row;
  logic           active_col;
  logic           in_snap;
  logic [17:0]    ahead_sum;
  logic [17:0]    ahead_wrap;
  logic [3:0]     pre_needed;
  logic [14:0]    row_cyc_reg;
  logic [14:0]    row_cyc_next;
  logic [16:0]    row_idx_reg;
  logic [16:0]    row_idx_next;
  video_timing_s  vt_reg;
  video_timing_s  vt_next;
  logic           pclk_reg;
  logic           pclk_next;
  capture_state_e state_reg;
  capture_state_e state_next;
  logic [16:0]    phase_reg;
  logic [16:0]    phase_next;
  logic           strobe_reg;
  logic           strobe_next;

  line_clock_divider u_div (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .divide_sel (timing_cfg.line_clock_divide_sel),
    .line_tick  (line_tick),
    .phase_high (pclk_raw)
  );

  trigger_former u_trig (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .snapshot_pin (snapshot_pin),
    .level_sel    (still_cfg.trigger_level_sel),
    .accept       (state_reg == ST_FREEZE && still_cfg.still_capture_enable),
    .trigger      (trigger)
  );

  // =====================================================
  // Geometry
  always_comb begin
    in_snap     = (state_reg != ST_VIDEO) && (state_reg != ST_FREEZE);
    npix        = (12'(timing_cfg.window_last_column) - 12'(timing_cfg.window_first_column)
                  + 12'h1) >> timing_cfg.horiz_subsample;
    nrows       = (12'(timing_cfg.window_last_row) - 12'(timing_cfg.window_first_row)
                  + 12'h1) >> timing_cfg.vert_subsample;
    eff_partial = timing_cfg.partial_exposure_enable && (timing_cfg.reset_ahead != '0)
                  && !in_snap;
    pix_lo      = `ROW_OP_CYCLES + (eff_partial ? `PARTIAL_OVH_CYCLES : 15'h0);
    row_len     = pix_lo + 15'(npix) + 15'(timing_cfg.row_extension);
    // Snap phases count bare frames; the extension is video and freeze only
    frame_len   = 17'(nrows) + (in_snap ? 17'h0 : 17'(timing_cfg.frame_extension));
    row_last    = (row_cyc_reg == row_len - 15'h1);
    row_end     = line_tick && row_last;
    frame_end   = row_end && (row_idx_reg == frame_len - 17'h1);
  end

  // =====================================================
  // Row and frame counters
  always_comb begin
    row_cyc_next = row_cyc_reg;
    row_idx_next = row_idx_reg;
    if (restart) begin
      row_cyc_next = '0;
      row_idx_next = '0;
    end else if (line_tick) begin
      if (row_last) begin
        row_cyc_next = '0;
        row_idx_next = (row_idx_reg == frame_len - 17'h1) ? 17'h0 : row_idx_reg + 17'h1;
      end else begin
        row_cyc_next = row_cyc_reg + 15'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      row_cyc_reg <= '0;
      row_idx_reg <= '0;
    end else begin
      row_cyc_reg <= row_cyc_next;
      row_idx_reg <= row_idx_next;
    end
  end

  // =====================================================
  // Pixel window, row reset and pixel clock
  always_comb begin
    active_row = (row_idx_reg < 17'(nrows));
    active_col = (row_cyc_reg >= pix_lo) && (row_cyc_reg < pix_lo + 15'(npix));
    ahead_sum  = 18'(row_idx_reg) + 18'(timing_cfg.reset_ahead);
    ahead_wrap = (ahead_sum >= 18'(frame_len)) ? ahead_sum - 18'(frame_len) : ahead_sum;
    vt_next = '0;
    vt_next.pixel_valid = !restart && active_row && active_col
                          && (state_reg == ST_VIDEO || state_reg == ST_READOUT);
    vt_next.row_start   = !restart && line_tick && (row_cyc_reg == '0);
    vt_next.frame_start = vt_next.row_start && (row_idx_reg == '0);
    if (vt_next.row_start && state_reg == ST_VIDEO && eff_partial) begin
      vt_next.reset_row_strobe = (ahead_wrap < 18'(nrows));
      vt_next.reset_row        = ahead_wrap[16:0];
    end else if (vt_next.row_start && state_reg == ST_PRE_RESET) begin
      vt_next.reset_row_strobe = active_row;
      vt_next.reset_row        = row_idx_reg;
    end
    pclk_next = pclk_raw;
    if (timing_cfg.pixel_clock_data_ready_sel) begin
      // Gate with the unregistered valid so the pulse lines up with the data
      pclk_next = pclk_raw && vt_next.pixel_valid;
    end
    pclk_next = pclk_next ^ timing_cfg.pixel_clock_invert;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vt_reg   <= '0;
      pclk_reg <= 1'b0;
    end else begin
      vt_reg   <= vt_next;
      pclk_reg <= pclk_next;
    end
  end

  // =====================================================
  // Still capture sequencer
  always_comb begin
    pre_needed = (still_cfg.pre_reset_frame_count > `PRE_RESET_MAX) ?
                 `PRE_RESET_MAX : still_cfg.pre_reset_frame_count;
    if (still_cfg.external_shutter_sel && pre_needed < `PRE_RESET_MIN_EXT) begin
      pre_needed = `PRE_RESET_MIN_EXT;
    end
    state_next = state_reg;
    phase_next = phase_reg;
    case (state_reg)
      ST_VIDEO: begin
        if (still_cfg.still_capture_enable && frame_end) begin
          state_next = ST_FREEZE;
        end
      end
      ST_FREEZE: begin
        if (!still_cfg.still_capture_enable) begin
          state_next = ST_VIDEO;
        end else if (trigger) begin
          state_next = ST_PRE_RESET;
        end
      end
      ST_PRE_RESET: begin
        if (phase_reg == 17'(pre_needed)) begin
          state_next = ST_CAPTURE;
        end else if (frame_end) begin
          phase_next = phase_reg + 17'h1;
        end
      end
      ST_CAPTURE: begin
        if (phase_reg == 17'(still_cfg.still_exposure)) begin
          state_next = ST_READOUT;
        end else if (row_end) begin
          phase_next = phase_reg + 17'h1;
        end
      end
      ST_READOUT: begin
        if (frame_end) begin
          state_next = still_cfg.still_capture_enable ? ST_FREEZE : ST_VIDEO;
        end
      end
      default: begin
        state_next = ST_VIDEO;
      end
    endcase
    if (state_next != state_reg) begin
      phase_next = '0;
    end
    strobe_next = (state_next == ST_CAPTURE) ||
                  (state_next == ST_READOUT && !still_cfg.external_shutter_sel);
  end

  assign restart = (state_next != state_reg);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_VIDEO;
      phase_reg  <= '0;
      strobe_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      strobe_reg <= strobe_next;
    end
  end

  assign pixel_clock   = pclk_reg;
  assign video_timing  = vt_reg;
  assign strobe_sync   = strobe_reg;
  assign capture_state = state_reg;

  // =====================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic [14:0] ticks_since;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ticks_since <= '0;
    end else if (restart || row_end) begin
      ticks_since <= '0;
    end else if (line_tick) begin
      ticks_since <= ticks_since + 15'h1;
    end
  end

  sequence snap_entry;
    (state_reg == ST_FREEZE && still_cfg.still_capture_enable && trigger) ##1
    (state_reg == ST_PRE_RESET);
  endsequence

  div_by_two_a: assert property (
    (timing_cfg.line_clock_divide_sel == `DIV_BY2 && line_tick) ##1
    (timing_cfg.line_clock_divide_sel == `DIV_BY2) [*2] |-> line_tick && !$past(line_tick))
    else $error("line tick not every second cycle");
  pclk_gate_a: assert property (
    ($past(timing_cfg.pixel_clock_data_ready_sel) && !$past(timing_cfg.pixel_clock_invert)
     && pixel_clock) |-> video_timing.pixel_valid)
    else $error("pixel clock pulsed without valid pixel");
  pclk_invert_a: assert property (
    ($past(timing_cfg.pixel_clock_invert) && !$past(timing_cfg.pixel_clock_data_ready_sel))
    |-> pixel_clock != $past(pclk_raw))
    else $error("pixel clock not inverted");
  row_length_a: assert property (
    row_end |-> ticks_since == row_len - 15'h1)
    else $error("row length wrong");
  video_freeze_a: assert property (
    (state_reg == ST_VIDEO ##1 state_reg == ST_FREEZE) |-> $past(frame_end))
    else $error("freeze entered outside frame end");
  freeze_video_a: assert property (
    (state_reg == ST_FREEZE && !still_cfg.still_capture_enable) |=> state_reg == ST_VIDEO)
    else $error("freeze did not return to video");
  snap_strobe_a: assert property (
    snap_entry |-> !strobe_sync ##1 (strobe_sync == (state_reg == ST_CAPTURE)))
    else $error("strobe active during array reset");
  capture_strobe_a: assert property (
    (state_reg == ST_READOUT && !still_cfg.external_shutter_sel) |-> strobe_sync)
    else $error("strobe inactive in normal readout");
  shutter_min_a: assert property (
    (state_reg == ST_PRE_RESET && still_cfg.external_shutter_sel && phase_reg == '0)
    |=> state_reg == ST_PRE_RESET)
    else $error("shutter mode skipped array reset");
  readout_end_a: assert property (
    (state_reg == ST_READOUT && frame_end) |=>
    state_reg == ($past(still_cfg.still_capture_enable) ? ST_FREEZE : ST_VIDEO))
    else $error("wrong state after readout");
  no_partial_a: assert property (
    in_snap |-> pix_lo == `ROW_OP_CYCLES)
    else $error("partial overhead in snapshot");

endmodule

// ---- hw/sensor_timing_pkg.sv ----
// Types shared by the sensor frame timing design.
// Assumes the constants header is compiled alongside.
package sensor_timing_pkg;

  // =====================================================
  // Capture state, Gray coded along video-freeze-snap path
  typedef enum logic [2:0] {
    ST_VIDEO     = 3'h0,
    ST_FREEZE    = 3'h1,
    ST_PRE_RESET = 3'h3,
    ST_CAPTURE   = 3'h2,
    ST_READOUT   = 3'h6
  } capture_state_e;

  // =====================================================
  // Configuration groups
  typedef struct packed {
    logic [1:0]  line_clock_divide_sel;
    logic        pixel_clock_data_ready_sel;
    logic        pixel_clock_invert;
    logic [10:0] window_first_column;
    logic [10:0] window_last_column;
    logic [10:0] window_first_row;
    logic [10:0] window_last_row;
    logic        horiz_subsample;
    logic        vert_subsample;
    logic [12:0] row_extension;
    logic [14:0] frame_extension;
    logic        partial_exposure_enable;
    logic [14:0] reset_ahead;
  } timing_cfg_s;

  typedef struct packed {
    logic        still_capture_enable;
    logic        trigger_level_sel;
    logic        external_shutter_sel;
    logic [3:0]  pre_reset_frame_count;
    logic [15:0] still_exposure;
  } still_cfg_s;

  // =====================================================
  // Video timing outputs
  typedef struct packed {
    logic        pixel_valid;
    logic        row_start;
    logic        frame_start;
    logic        reset_row_strobe;
    logic [16:0] reset_row;
  } video_timing_s;

endpackage

// ---- hw/sensor_timing_regs.svh ----
// Timing constants of the sensor frame timing block.
// Assumes inclusion by bare name; definitions only.
`ifndef SENSOR_TIMING_REGS_SVH
`define SENSOR_TIMING_REGS_SVH

// =====================================================
// Line clock divider
`define DIV_UNDIVIDED      2'h0
`define DIV_BY2            2'h1
`define DIV_BY4            2'h2
`define DIV_BY6            2'h3
`define DIV1_LAST          3'h0
`define DIV2_LAST          3'h1
`define DIV4_LAST          3'h3
`define DIV6_LAST          3'h5

// =====================================================
// Row and frame timing, in line clock cycles
`define ROW_OP_CYCLES      15'h008c
`define PARTIAL_OVH_CYCLES 15'h0022

// =====================================================
// Still capture limits
`define PRE_RESET_MAX      4'h8
`define PRE_RESET_MIN_EXT  4'h1

`endif

// ---- hw/trigger_former.sv ----
// Internal trigger from the snapshot pin, pulse or level form.
// Assumes the pin is synchronous to the system clock.
`timescale 1ns/1ps
module trigger_former
  import sensor_timing_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic snapshot_pin,
  input  wire logic level_sel,
  input  wire logic accept,
  output logic      trigger
);

  logic fired_reg;
  logic fired_next;

  // =====================================================
  // Pulse form: one pulse per activation, held until the sequencer accepts it; level form follows the pin
  always_comb begin
    trigger    = snapshot_pin && (level_sel || !fired_reg);
    fired_next = snapshot_pin && (fired_reg || (trigger && accept));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fired_reg <= 1'b0;
    end else begin
      fired_reg <= fired_next;
    end
  end

endmodule

// ---- verif/capture_host_model.sv ----
// Host side model: drives the snapshot pin for a set number of cycles.
// Assumes the bench pulses fire for one cycle; the pin has a pull-down.
`timescale 1ns/1ps
module capture_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        fire,
  input  wire logic [31:0] hold_len,
  output logic             snapshot_pin
);
  // ==========================================================
  // Hold counter
  logic [31:0] left_reg;

  initial snapshot_pin = 1'b0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_reg <= 32'h0;
    end else if (fire) begin
      left_reg <= hold_len;
    end else if (left_reg != 32'h0) begin
      left_reg <= left_reg - 32'h1;
    end
  end

  // Released pin falls to its pull-down level, never keeps the last value
  always @(negedge clk_sys) snapshot_pin <= (left_reg != 32'h0);
endmodule

// ---- verif/tb_sensor_frame_timing.sv ----
// Self-checking bench for the frame timing and still capture block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_sensor_frame_timing import sensor_timing_pkg::*;;
  typedef struct {int frame; int row; int valid; int rises; int strobes; int ticks;
                  int rsum;} frame_note_s;
  typedef struct {capture_state_e st; logic sb; int dur;} state_note_s;

  logic           clk_sys = 1'b0;
  logic           rst = 1'b1;
  timing_cfg_s    tcfg;
  still_cfg_s     scfg;
  logic           fire;
  logic [31:0]    hold;
  logic           snapshot_pin;
  logic           pixel_clock;
  logic           line_tick;
  logic           strobe_sync;
  video_timing_s  vt;
  capture_state_e cs;
  int             err_count = 0;
  int             check_count = 0;
  int             seed = 37;
  frame_note_s    fq[$];
  state_note_s    sq[$];

  always #4 clk_sys = ~clk_sys;

  sensor_frame_timing DUT (.clk_sys(clk_sys), .rst(rst), .timing_cfg(tcfg), .still_cfg(scfg),
    .snapshot_pin(snapshot_pin), .pixel_clock(pixel_clock), .line_tick(line_tick),
    .video_timing(vt), .strobe_sync(strobe_sync), .capture_state(cs));
  capture_host_model host (.clk_sys(clk_sys), .rst(rst), .fire(fire), .hold_len(hold),
    .snapshot_pin(snapshot_pin));

  // ==========================================================
  // Helpers
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction

  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic timeout_hit;
    err_count++;
    $display("wait limit hit at %0t", $time);
    results();
  endtask

  task automatic wait_fs(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk_sys);
      if (vt.frame_start === 1'b1) return;
    end
    timeout_hit();
  endtask

  task automatic wait_st(input capture_state_e s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk_sys);
      if (cs === s) return;
    end
    timeout_hit();
  endtask

  task automatic note(input capture_state_e s, input logic b, input int d);
    state_note_s n;
    n.st = s;
    n.sb = b;
    n.dur = d;
    sq.push_back(n);
  endtask

  // ==========================================================
  // Frame monitor: measures one whole frame per note
  bit          on;
  int          fc, r1, r2, rsn, vc, pr, sc, tc, rs;
  logic        pd;
  frame_note_s fe;
  always @(posedge clk_sys) begin
    if (rst) begin
      on = 0;
      pd = 1'b0;
    end else begin
      if (vt.frame_start === 1'b1 && on) begin
        fe = fq.pop_front();
        on = 0;
        `CHECK(fc, fe.frame)
        `CHECK(r2 - r1, fe.row)
        `CHECK(vc, fe.valid)
        `CHECK(pr, fe.rises)
        `CHECK(sc, fe.strobes)
        `CHECK(rs, fe.rsum)
        `CHECK(tc, fe.ticks)
      end
      if (vt.frame_start === 1'b1 && !on && fq.size() > 0) begin
        on = 1;
        {fc, r1, r2, rsn, vc, pr, sc, tc, rs} = '0;
      end
      if (on) begin
        if (vt.row_start === 1'b1) begin
          if (rsn == 0) r1 = fc;
          if (rsn == 1) r2 = fc;
          rsn++;
        end
        vc += (vt.pixel_valid === 1'b1);
        pr += (pixel_clock === 1'b1 && pd === 1'b0);
        sc += (vt.reset_row_strobe === 1'b1);
        if (vt.reset_row_strobe === 1'b1) rs += int'(vt.reset_row);
        tc += (line_tick === 1'b1);
        fc++;
      end
      pd = pixel_clock;
    end
  end

  // ==========================================================
  // State monitor: one note per state left
  capture_state_e sp;
  int             sd;
  logic           ss;
  state_note_s    se;
  always @(posedge clk_sys) begin
    if (rst) begin
      sp = ST_VIDEO;
      sd = 0;
      ss = 1'b0;
    end else if (cs !== sp) begin
      if (sq.size() == 0) begin
        `CHECK(cs, sp)
      end else begin
        se = sq.pop_front();
        `CHECK(sp, se.st)
        `CHECK(ss, se.sb)
        if (se.dur != 0) `CHECK(sd, se.dur)
      end
      sp = cs;
      sd = 1;
      ss = strobe_sync;
    end else begin
      sd++;
      // A strobe that moves inside a state can never match a note
      if (strobe_sync !== ss) ss = 1'bx;
    end
  end

  // ==========================================================
  // Video timing runs with random windows
  task automatic run_frame(input int sel);
    int div, f, npix, nr, fext, rext, act, rt;
    frame_note_s n;
    // Config moves only at a frame start, so no counter sits past a shorter limit
    wait_fs(40000);
    tcfg.line_clock_divide_sel = 2'(sel);
    tcfg.pixel_clock_data_ready_sel = 1'(rnd(2));
    tcfg.pixel_clock_invert = 1'(rnd(2));
    tcfg.horiz_subsample = 1'(rnd(2));
    tcfg.vert_subsample = 1'(rnd(2));
    npix = 2 + rnd(7);
    f = rnd(4);
    tcfg.window_first_column = 11'(f);
    tcfg.window_last_column = 11'(f + (npix << tcfg.horiz_subsample) - 1);
    nr = 2 + rnd(2);
    f = rnd(4);
    tcfg.window_first_row = 11'(f);
    tcfg.window_last_row = 11'(f + (nr << tcfg.vert_subsample) - 1);
    rext = rnd(16);
    fext = rnd(2);
    tcfg.row_extension = 13'(rext);
    tcfg.frame_extension = 15'(fext);
    tcfg.partial_exposure_enable = 1'(rnd(2));
    // Reset-ahead stays inside one frame, as exposure must not change frame rate
    tcfg.reset_ahead = 15'(rnd(nr + fext));
    div = (sel == 0) ? 1 : 2 * sel;
    act = tcfg.partial_exposure_enable && tcfg.reset_ahead != 15'h0;
    rt = 140 + (act ? 34 : 0) + npix + rext;
    n.frame = (nr + fext) * rt * div;
    n.row = rt * div;
    n.valid = nr * npix * div;
    if (tcfg.pixel_clock_data_ready_sel) n.rises = (div == 1) ? nr : nr * npix;
    else n.rises = (div == 1) ? 0 : n.frame / div;
    n.strobes = act ? nr : 0;
    n.ticks = n.frame / div;
    // Every residue of the frame comes up once; those inside the window strobe
    n.rsum = act ? nr * (nr - 1) / 2 : 0;
    // Note lands after this start, so the first clean frame is measured
    @(negedge clk_sys);
    fq.push_back(n);
    for (int i = 0; i < 80000 && fq.size() > 0; i++) @(negedge clk_sys);
    if (fq.size() > 0) timeout_hit();
  endtask

  // ==========================================================
  // Still capture: 2 rows of 148 cycles, undivided line clock
  task automatic snap_run(input bit lvl);
    int n, nn, e, pre, cap, total;
    n = lvl ? 1 + rnd(8) : rnd(10);
    e = rnd(4);
    nn = (n > 8) ? 8 : n;
    if (lvl && nn == 0) nn = 1;
    // Reset and capture phases end one clock after their last counted frame or row; readout ends on its frame end
    pre = nn * 296 + 1;
    cap = e * 148 + 1;
    total = pre + cap + 296;
    @(negedge clk_sys);
    scfg.trigger_level_sel = lvl;
    scfg.external_shutter_sel = lvl;
    scfg.pre_reset_frame_count = 4'(n);
    scfg.still_exposure = 16'(e);
    scfg.still_capture_enable = 1'b1;
    note(ST_VIDEO, 1'b0, 0);
    note(ST_FREEZE, 1'b0, 0);
    for (int k = 0; k <= int'(lvl); k++) begin
      note(ST_PRE_RESET, 1'b0, pre);
      note(ST_CAPTURE, 1'b1, cap);
      note(ST_READOUT, !lvl, 296);
      if (k == 0) note(ST_FREEZE, 1'b0, 0);
    end
    // Video frame is 3 rows of 182 cycles
    wait_st(ST_FREEZE, 600);
    hold = lvl ? total + 5 : total + 600;
    fire = 1'b1;
    @(negedge clk_sys);
    fire = 1'b0;
    wait_st(ST_READOUT, 5000);
    wait_st(ST_FREEZE, 400);
    if (lvl) begin
      wait_st(ST_READOUT, 5000);
    end else begin
      for (int i = 0; i < 2000 && snapshot_pin; i++) @(negedge clk_sys);
      if (snapshot_pin) timeout_hit();
      repeat (10) @(negedge clk_sys);
    end
    scfg.still_capture_enable = 1'b0;
    wait_st(ST_VIDEO, 400);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    tcfg = '0;
    scfg = '0;
    fire = 1'b0;
    hold = 32'h0;
    tcfg.window_last_column = 11'h007;
    tcfg.window_last_row = 11'h001;
    tcfg.partial_exposure_enable = 1'b1;
    tcfg.reset_ahead = 15'h0003;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) run_frame(i % 4);
    @(negedge clk_sys);
    tcfg = '0;
    tcfg.window_last_column = 11'h007;
    tcfg.window_last_row = 11'h001;
    tcfg.frame_extension = 15'h0001;
    tcfg.partial_exposure_enable = 1'b1;
    tcfg.reset_ahead = 15'h0003;
    wait_fs(40000);
    wait_fs(40000);
    snap_run(1'b0);
    snap_run(1'b1);
    repeat (5) @(negedge clk_sys);
    if (sq.size() != 0) timeout_hit();
    results();
  end
endmodule
